// *** logic/ptpmt_pkg.sv ***
// register map, field positions and reset values of the ptp master timer block
package ptpmt_pkg;
  localparam int PTPMT_AW = 8;
  localparam logic [7:0] ADDR_MASTER_TIME_NOW = 8'h00;
  localparam logic [7:0] ADDR_SYNC_CAPTURE_TIME0 = 8'h04;
  localparam logic [7:0] ADDR_SYNC_CAPTURE_TIME1 = 8'h08;
  localparam logic [7:0] ADDR_TIMER_EVENT_FLAGS = 8'h0c;
  localparam logic [7:0] ADDR_GEN_CLOCK_LOW_PHASE = 8'h10;
  localparam logic [7:0] ADDR_GEN_CLOCK_HIGH_PHASE = 8'h14;
  localparam logic [7:0] ADDR_GEN_CLOCK_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_RATE_ADJUST_CONTROL = 8'h1c;
  localparam logic [7:0] ADDR_RATE_ADJUST_INTERVAL = 8'h20;
  localparam logic [7:0] ADDR_SYNC_PRESET_TIME0 = 8'h24;
  localparam logic [7:0] ADDR_SYNC_PRESET_TIME1 = 8'h28;
  localparam logic [7:0] ADDR_MASTER_WRAP_LIMIT = 8'h2c;
  localparam logic [7:0] ADDR_SYNC_CONTROL = 8'h30;
  localparam logic [7:0] ADDR_INTERRUPT_MASK = 8'h34;
  localparam int GEN_ENABLE_BIT = 0;
  localparam int GEN_ALIGN_BIT = 2;
  localparam int ADJ_DEFERRED_BIT = 0;
  localparam int ADJ_ENABLE_BIT = 1;
  localparam int ADJ_DIRECTION_BIT = 2;
  localparam int FLAG_WRAP_BIT = 0;
  localparam int FLAG_CAPTURE_LSB = 1;
  localparam int FLAG_UPDATE_BIT = 3;
  localparam logic [29:0] GEN_PHASE_RESET = 30'h0000_30d4;
  localparam logic [29:0] ADJ_INTERVAL_RESET = 30'h0000_4e1f;
  localparam logic [29:0] WRAP_LIMIT_RESET = 30'h3b9a_ca00;
  localparam logic [29:0] TIME_RESET = 30'h0000_0000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int CAPTURE_LAG_TICKS = 3;
  localparam logic [29:0] NS_PER_TICK = 30'(CLK_PERIOD_NS);
endpackage

// *** logic/ptpmt_top.sv ***
// ptp master timer: counter, rate correction, generated clock, sync capture, apb slave
// Function
// - generated clock low for N+1 cycles
// - clock output only while enable bit set
// - sync-enable aligns generated clock to master sync
// - direction clear adds one, set subtracts one
// - correction only while adjust enable set
// - deferred bit delays new values to sync
// - 30-bit interval, resets to 0x4E1F
// - sync rising edge loads preset time
// - live master time readable, zero after reset
// - snapshot time only when capture flag clear
// - snapshot lags edge by synchronizer ticks
// - sticky capture flag per input, bits 2:1
// - sticky wrap flag bit 0 on wrap
// - sticky update-done flag bit 3 when deferred
// - generated clock high for N+1 cycles
// - counter wraps to zero at limit
// - preset load only when sync load enabled
// - interrupt only for masked-in events
//
// Decided for this implementation: register access over APB.
`timescale 1ns/100ps
module ptpmt_top
  import ptpmt_pkg::*;
#(
  parameter int SYNC_INPUTS = 2
)(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PTPMT_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] sync_in,
  output logic gen_clock_out,
  output logic gen_clock_oe,
  output logic master_sync_pulse,
  output logic irq
);
  logic [29:0] master_time_value;
  logic [29:0] sync_capture_value [2];
  logic [29:0] sync_preset_value [2];
  logic [29:0] gen_clock_low_count;
  logic [29:0] gen_clock_high_count;
  logic [29:0] master_wrap_limit;
  logic [29:0] rate_adjust_cycles;
  logic [29:0] active_cycles;
  logic active_direction;
  logic adjust_pending;
  logic gen_clock_output_enable;
  logic gen_clock_align_enable;
  logic rate_adjust_direction;
  logic rate_adjust_enable;
  logic rate_adjust_deferred;
  logic [1:0] external_sync_load_enable;
  logic [1:0] capture_interrupt_mask;
  logic wrap_interrupt_mask;
  logic [3:0] flags;
  logic [1:0] sync_meta;
  logic [1:0] sync_sync;
  logic [1:0] sync_prev;
  logic [1:0] sync_rise;
  logic [29:0] adj_count;
  logic adj_tick;
  logic wrap_now;
  logic [29:0] gen_count;
  logic gen_level;
  logic wr_en;
  logic rd_en;
  logic [3:0] clear_mask;
  logic [3:0] set_mask;
  logic [31:0] next_prdata;
  logic next_pslverr;

  assign wr_en = psel && penable && pready && pwrite;
  assign rd_en = psel && !penable && !pwrite;
  assign clear_mask = (wr_en && paddr == ADDR_TIMER_EVENT_FLAGS && pstrb[0]) ? pwdata[3:0] : 4'h0;

  // two-stage synchroniser then edge detect on the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_meta <= 2'h0;
      sync_sync <= 2'h0;
      sync_prev <= 2'h0;
    end
    else
    begin
      sync_meta <= sync_in;
      sync_sync <= sync_meta;
      sync_prev <= sync_sync;
    end
  end
  assign sync_rise = sync_sync & ~sync_prev;

  // correction interval counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      adj_count <= 30'h0000_0000;
    else if (adj_tick || !rate_adjust_enable)
      adj_count <= 30'h0000_0000;
    else
      adj_count <= adj_count + 30'h0000_0001;
  end
  assign adj_tick = rate_adjust_enable && ((adj_count + 30'h0000_0001) >= active_cycles);

  assign wrap_now = (master_time_value + NS_PER_TICK) >= master_wrap_limit;

  // master time counter
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      master_time_value <= TIME_RESET;
    else if (sync_rise[0] && external_sync_load_enable[0])
      master_time_value <= sync_preset_value[0];
    else if (sync_rise[1] && external_sync_load_enable[1])
      master_time_value <= sync_preset_value[1];
    else if (wrap_now)
      master_time_value <= TIME_RESET;
    else if (adj_tick && !active_direction)
      master_time_value <= master_time_value + NS_PER_TICK + 30'h0000_0001;
    else if (adj_tick && active_direction)
      master_time_value <= master_time_value + NS_PER_TICK - 30'h0000_0001;
    else
      master_time_value <= master_time_value + NS_PER_TICK;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      master_sync_pulse <= 1'b0;
    else
      master_sync_pulse <= wrap_now;
  end

  // active adjustment values, immediate or deferred to a wrap
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      active_cycles <= ADJ_INTERVAL_RESET;
      active_direction <= 1'b0;
      adjust_pending <= 1'b0;
    end
    else if (!rate_adjust_deferred)
    begin
      active_cycles <= rate_adjust_cycles;
      active_direction <= rate_adjust_direction;
      adjust_pending <= 1'b0;
    end
    else if (wrap_now && adjust_pending)
    begin
      active_cycles <= rate_adjust_cycles;
      active_direction <= rate_adjust_direction;
      adjust_pending <= 1'b0;
    end
    else if (wr_en && (paddr == ADDR_RATE_ADJUST_INTERVAL || paddr == ADDR_RATE_ADJUST_CONTROL))
      adjust_pending <= 1'b1;
  end

  // sticky flags, set wins over clear
  always_comb
  begin
    set_mask = 4'h0;
    set_mask[FLAG_WRAP_BIT] = wrap_now;
    set_mask[FLAG_CAPTURE_LSB +: 2] = sync_rise;
    set_mask[FLAG_UPDATE_BIT] = rate_adjust_deferred && wrap_now && adjust_pending;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      flags <= 4'h0;
    else
      flags <= (flags & ~clear_mask) | set_mask;
  end

  // snapshots only while the input's flag is clear
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_capture_value[0] <= TIME_RESET;
      sync_capture_value[1] <= TIME_RESET;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
        if (sync_rise[i] && !flags[FLAG_CAPTURE_LSB + i])
          sync_capture_value[i] <= master_time_value;
    end
  end

  // generated clock: low phase then high phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gen_count <= 30'h0000_0000;
      gen_level <= 1'b0;
    end
    else if (!gen_clock_output_enable || (gen_clock_align_enable && wrap_now))
    begin
      gen_count <= 30'h0000_0000;
      gen_level <= 1'b0;
    end
    else if (!gen_level && gen_count >= gen_clock_low_count)
    begin
      gen_count <= 30'h0000_0000;
      gen_level <= 1'b1;
    end
    else if (gen_level && gen_count >= gen_clock_high_count)
    begin
      gen_count <= 30'h0000_0000;
      gen_level <= 1'b0;
    end
    else
      gen_count <= gen_count + 30'h0000_0001;
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gen_clock_out <= 1'b0;
      gen_clock_oe <= 1'b0;
    end
    else
    begin
      gen_clock_out <= gen_level && gen_clock_output_enable;
      gen_clock_oe <= gen_clock_output_enable;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq <= 1'b0;
    else
      irq <= |(flags[2:0] & {capture_interrupt_mask, wrap_interrupt_mask});
  end

  // configuration registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      gen_clock_low_count <= GEN_PHASE_RESET;
      gen_clock_high_count <= GEN_PHASE_RESET;
      gen_clock_output_enable <= 1'b0;
      gen_clock_align_enable <= 1'b0;
      rate_adjust_direction <= 1'b0;
      rate_adjust_enable <= 1'b0;
      rate_adjust_deferred <= 1'b0;
      rate_adjust_cycles <= ADJ_INTERVAL_RESET;
      sync_preset_value[0] <= TIME_RESET;
      sync_preset_value[1] <= TIME_RESET;
      master_wrap_limit <= WRAP_LIMIT_RESET;
      external_sync_load_enable <= 2'h0;
      capture_interrupt_mask <= 2'h0;
      wrap_interrupt_mask <= 1'b0;
    end
    else if (wr_en && pstrb == 4'hf)
    begin
      case (paddr)
        ADDR_GEN_CLOCK_LOW_PHASE: gen_clock_low_count <= pwdata[29:0];
        ADDR_GEN_CLOCK_HIGH_PHASE: gen_clock_high_count <= pwdata[29:0];
        ADDR_GEN_CLOCK_CONTROL:
        begin
          gen_clock_output_enable <= pwdata[GEN_ENABLE_BIT];
          gen_clock_align_enable <= pwdata[GEN_ALIGN_BIT];
        end
        ADDR_RATE_ADJUST_CONTROL:
        begin
          rate_adjust_deferred <= pwdata[ADJ_DEFERRED_BIT];
          rate_adjust_enable <= pwdata[ADJ_ENABLE_BIT];
          rate_adjust_direction <= pwdata[ADJ_DIRECTION_BIT];
        end
        ADDR_RATE_ADJUST_INTERVAL: rate_adjust_cycles <= pwdata[29:0];
        ADDR_SYNC_PRESET_TIME0: sync_preset_value[0] <= pwdata[29:0];
        ADDR_SYNC_PRESET_TIME1: sync_preset_value[1] <= pwdata[29:0];
        ADDR_MASTER_WRAP_LIMIT: master_wrap_limit <= pwdata[29:0];
        ADDR_SYNC_CONTROL: external_sync_load_enable <= pwdata[2:1];
        ADDR_INTERRUPT_MASK:
        begin
          capture_interrupt_mask <= pwdata[2:1];
          wrap_interrupt_mask <= pwdata[0];
        end
        default: ;
      endcase
    end
  end

  // read mux
  always_comb
  begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (paddr)
      ADDR_MASTER_TIME_NOW: next_prdata = {2'b00, master_time_value};
      ADDR_SYNC_CAPTURE_TIME0: next_prdata = {2'b00, sync_capture_value[0]};
      ADDR_SYNC_CAPTURE_TIME1: next_prdata = {2'b00, sync_capture_value[1]};
      ADDR_TIMER_EVENT_FLAGS: next_prdata = {28'h000_0000, flags};
      ADDR_GEN_CLOCK_LOW_PHASE: next_prdata = {2'b00, gen_clock_low_count};
      ADDR_GEN_CLOCK_HIGH_PHASE: next_prdata = {2'b00, gen_clock_high_count};
      ADDR_GEN_CLOCK_CONTROL: next_prdata = {29'h0, gen_clock_align_enable, 1'b0, gen_clock_output_enable};
      ADDR_RATE_ADJUST_CONTROL: next_prdata = {29'h0, rate_adjust_direction, rate_adjust_enable, rate_adjust_deferred};
      ADDR_RATE_ADJUST_INTERVAL: next_prdata = {2'b00, rate_adjust_cycles};
      ADDR_SYNC_PRESET_TIME0: next_prdata = {2'b00, sync_preset_value[0]};
      ADDR_SYNC_PRESET_TIME1: next_prdata = {2'b00, sync_preset_value[1]};
      ADDR_MASTER_WRAP_LIMIT: next_prdata = {2'b00, master_wrap_limit};
      ADDR_SYNC_CONTROL: next_prdata = {29'h0, external_sync_load_enable, 1'b0};
      ADDR_INTERRUPT_MASK: next_prdata = {29'h0, capture_interrupt_mask, wrap_interrupt_mask};
      default: next_pslverr = 1'b1;
    endcase
  end

  // answer one cycle after setup: pready high in the access phase
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && next_pslverr;
      if (rd_en)
        prdata <= next_prdata;
    end
  end

  a_wrap_flag: assert property (@(posedge pclk) disable iff (!presetn)
    wrap_now |=> flags[FLAG_WRAP_BIT])
    else $error("wrap did not set flag");
  a_capture_hold: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_rise[0] && flags[1]) |=> $stable(sync_capture_value[0]))
    else $error("snapshot overwritten while flag set");
  a_preset_load: assert property (@(posedge pclk) disable iff (!presetn)
    (sync_rise[0] && external_sync_load_enable[0]) |=> master_time_value == $past(sync_preset_value[0]))
    else $error("preset not loaded");
  a_adjust_off: assert property (@(posedge pclk) disable iff (!presetn)
    (!rate_adjust_enable && !wrap_now && !(|(sync_rise & external_sync_load_enable)))
    |=> master_time_value == $past(master_time_value) + NS_PER_TICK)
    else $error("correction while disabled");
  a_clock_off: assert property (@(posedge pclk) disable iff (!presetn)
    !gen_clock_output_enable |=> !gen_clock_oe && !gen_clock_out)
    else $error("clock driven while disabled");
  a_irq_masked: assert property (@(posedge pclk) disable iff (!presetn)
    (flags[2:0] & {capture_interrupt_mask, wrap_interrupt_mask}) == 3'h0 |=> !irq)
    else $error("irq while masked");
  a_w1c_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (clear_mask[0] && !set_mask[0]) |=> !flags[0])
    else $error("flag not cleared");
  a_immediate_apply: assert property (@(posedge pclk) disable iff (!presetn)
    !rate_adjust_deferred |=> active_cycles == $past(rate_adjust_cycles))
    else $error("immediate update missing");
endmodule

// *** bench/ptpmt_partner.sv ***
// sync pulse source and generated clock sink for the ptp master timer
`timescale 1ns/100ps
module ptpmt_partner
#(
  parameter int PULSE_CYCLES = 4
)(
  input wire logic pclk,
  input wire logic [1:0] fire,
  input wire logic gen_clock_out,
  input wire logic gen_clock_oe,
  output logic [1:0] sync_in,
  output int low_len,
  output int high_len
);
  int cnt [2];
  int run;
  logic last;
  initial
  begin
    sync_in = 2'b00;
    cnt = '{0, 0};
    run = 0;
    last = 1'b0;
    low_len = 0;
    high_len = 0;
  end
  // one rising edge per request, held a few cycles, then low again
  always @(posedge pclk)
  begin
    for (int i = 0; i < 2; i++)
    begin
      if (fire[i] && cnt[i] == 0)
      begin
        sync_in[i] <= 1'b1;
        cnt[i] <= PULSE_CYCLES;
      end
      else if (cnt[i] > 0)
      begin
        cnt[i] <= cnt[i] - 1;
        if (cnt[i] == 1)
          sync_in[i] <= 1'b0;
      end
    end
  end
  // length of the last complete low and high run of the clock
  always @(posedge pclk)
  begin
    last <= gen_clock_out;
    if (gen_clock_oe !== 1'b1)
      run <= 0;
    else if (gen_clock_out !== last)
    begin
      if (last)
        high_len <= run;
      else
        low_len <= run;
      run <= 1;
    end
    else
      run <= run + 1;
  end
endmodule

// *** bench/tb_top.sv ***
// self-checking bench of the ptp master timer over apb
`timescale 1ns/100ps
module tb_top
  import ptpmt_pkg::*;
();
  typedef struct {logic [31:0] e; logic [31:0] m; logic se;} ptpmt_note_t;
  localparam logic [7:0] RA [8] = '{ADDR_SYNC_CAPTURE_TIME0, ADDR_TIMER_EVENT_FLAGS, ADDR_GEN_CLOCK_LOW_PHASE,
    ADDR_GEN_CLOCK_HIGH_PHASE, ADDR_GEN_CLOCK_CONTROL, ADDR_RATE_ADJUST_CONTROL, ADDR_RATE_ADJUST_INTERVAL,
    ADDR_MASTER_WRAP_LIMIT};
  localparam logic [31:0] RV [8] = '{32'h0, 32'h0, 32'h0000_30d4, 32'h0000_30d4, 32'h0, 32'h0, 32'h0000_4e1f,
    32'h3b9a_ca00};
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic [1:0] fire = 2'b00;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] sync_in;
  logic gen_clock_out;
  logic gen_clock_oe;
  logic master_sync_pulse;
  logic irq;
  int low_len;
  int high_len;
  ptpmt_note_t notes [$];
  int n_errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int rd_cyc = 0;
  logic [31:0] rd_last;
  int n_sync = 0;
  logic sp_d = 1'b0;

  ptpmt_top i_ptpmt_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_in(sync_in), .gen_clock_out(gen_clock_out), .gen_clock_oe(gen_clock_oe),
    .master_sync_pulse(master_sync_pulse), .irq(irq));
  ptpmt_partner i_ptpmt_partner (.pclk(pclk), .fire(fire), .gen_clock_out(gen_clock_out),
    .gen_clock_oe(gen_clock_oe), .sync_in(sync_in), .low_len(low_len), .high_len(high_len));

  initial
  begin
    forever #10 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // timeout guard and cycle count
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_errors++;
      wrap_up();
    end
  end

  // takes the oldest note whenever the slave answers
  always @(posedge pclk)
  begin
    if (psel && penable && pready === 1'b1 && notes.size() > 0)
    begin
      ptpmt_note_t n;
      n = notes.pop_front();
      rd_last = prdata;
      rd_cyc = cyc;
      chk(prdata & n.m, n.e);
      chk({31'b0, pslverr}, {31'b0, n.se});
    end
  end

  // counts sync pulses; generated clock must restart low after each wrap
  always @(posedge pclk)
  begin
    sp_d <= master_sync_pulse;
    if (master_sync_pulse === 1'b1)
      n_sync <= n_sync + 1;
    if (sp_d === 1'b1 && gen_clock_oe === 1'b1)
      chk({31'b0, gen_clock_out}, 32'h0);
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e,
    input logic [31:0] m, input logic se);
    notes.push_back('{e & m, m, se});
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    apb(1'b0, a, 32'h0, e, m, 1'b0);
  endtask

  task automatic idle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task automatic pulse(input int i);
    @(posedge pclk);
    fire[i] <= 1'b1;
    @(posedge pclk);
    fire[i] <= 1'b0;
    idle(12);
  endtask

  // time gained beyond the nominal rate over a measured span
  task automatic meas(output int adj, output int d);
    logic [31:0] t1;
    int c1;
    rd(ADDR_MASTER_TIME_NOW, 32'h0, 32'h0);
    t1 = rd_last;
    c1 = rd_cyc;
    idle(200);
    rd(ADDR_MASTER_TIME_NOW, 32'h0, 32'h0);
    d = rd_cyc - c1;
    adj = int'(rd_last - t1) - CLK_PERIOD_NS * d;
  endtask

  initial
  begin
    int adj;
    int d;
    logic [31:0] p;
    logic [31:0] cap;
    int s0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    void'($urandom(10));
    for (int i = 0; i < 8; i++)
      rd(RA[i], RV[i], 32'hffff_ffff);
    apb(1'b0, 8'h3c, 32'h0, 32'h0, 32'hffff_ffff, 1'b1);
    wr(ADDR_GEN_CLOCK_LOW_PHASE, 32'h0000_0003);
    wr(ADDR_GEN_CLOCK_HIGH_PHASE, 32'h0000_0005);
    wr(ADDR_GEN_CLOCK_CONTROL, 32'h0000_0001);
    idle(40);
    chk(32'(low_len), 32'h0000_0004);
    chk(32'(high_len), 32'h0000_0006);
    chk({31'b0, gen_clock_oe}, 32'h1);
    wr(ADDR_GEN_CLOCK_CONTROL, 32'h0);
    idle(4);
    chk({31'b0, gen_clock_oe}, 32'h0);
    meas(adj, d);
    chk(32'(adj), 32'h0);
    wr(ADDR_RATE_ADJUST_INTERVAL, 32'h0000_0009);
    wr(ADDR_RATE_ADJUST_CONTROL, 32'h0000_0002);
    meas(adj, d);
    chk({31'b0, adj >= d / 9 - 1 && adj <= d / 9 + 1}, 32'h1);
    wr(ADDR_RATE_ADJUST_CONTROL, 32'h0000_0006);
    meas(adj, d);
    chk({31'b0, -adj >= d / 9 - 1 && -adj <= d / 9 + 1}, 32'h1);
    wr(ADDR_TIMER_EVENT_FLAGS, 32'h0000_000f);
    wr(ADDR_INTERRUPT_MASK, 32'h0000_0001);
    wr(ADDR_RATE_ADJUST_CONTROL, 32'h0000_0003);
    wr(ADDR_RATE_ADJUST_INTERVAL, 32'h0000_0013);
    rd(ADDR_TIMER_EVENT_FLAGS, 32'h0, 32'h0000_0009);
    wr(ADDR_GEN_CLOCK_CONTROL, 32'h0000_0005);
    wr(ADDR_MASTER_WRAP_LIMIT, 32'h0000_03e8);
    s0 = n_sync;
    idle(100);
    chk({31'b0, n_sync - s0 >= 2 && n_sync - s0 <= 3}, 32'h1);
    chk({31'b0, irq}, 32'h1);
    rd(ADDR_TIMER_EVENT_FLAGS, 32'h0000_0009, 32'h0000_0009);
    wr(ADDR_INTERRUPT_MASK, 32'h0);
    idle(3);
    chk({31'b0, irq}, 32'h0);
    wr(ADDR_GEN_CLOCK_CONTROL, 32'h0);
    wr(ADDR_MASTER_WRAP_LIMIT, 32'h3b9a_ca00);
    wr(ADDR_RATE_ADJUST_CONTROL, 32'h0);
    wr(ADDR_TIMER_EVENT_FLAGS, 32'h0);
    rd(ADDR_TIMER_EVENT_FLAGS, 32'h0000_0009, 32'h0000_0009);
    wr(ADDR_TIMER_EVENT_FLAGS, 32'h0000_0009);
    rd(ADDR_TIMER_EVENT_FLAGS, 32'h0, 32'h0000_000f);
    p = {8'h00, 24'($urandom())};
    wr(ADDR_SYNC_CONTROL, 32'h0000_0002);
    wr(ADDR_SYNC_PRESET_TIME0, p);
    pulse(0);
    rd(ADDR_MASTER_TIME_NOW, 32'h0, 32'h0);
    chk({31'b0, rd_last >= p && rd_last < p + 32'd1000}, 32'h1);
    rd(ADDR_TIMER_EVENT_FLAGS, 32'h0000_0002, 32'h0000_0006);
    rd(ADDR_SYNC_CAPTURE_TIME0, 32'h0, 32'h0);
    cap = rd_last;
    pulse(0);
    rd(ADDR_SYNC_CAPTURE_TIME0, cap, 32'hffff_ffff);
    pulse(1);
    rd(ADDR_MASTER_TIME_NOW, 32'h0, 32'h0);
    chk({31'b0, rd_last >= p}, 32'h1);
    rd(ADDR_TIMER_EVENT_FLAGS, 32'h0000_0006, 32'h0000_0006);
    wr(ADDR_TIMER_EVENT_FLAGS, 32'h0000_0006);
    rd(ADDR_TIMER_EVENT_FLAGS, 32'h0, 32'h0000_0006);
    wrap_up();
  end
endmodule
